// ===== shared/eep_params.svh
`ifndef EEP_PARAMS_SVH
`define EEP_PARAMS_SVH

`define EEP_CLK_PERIOD_NS 100
`define EEP_HOLD_NS 300
`define EEP_HOLD_CYC \
	((`EEP_HOLD_NS + `EEP_CLK_PERIOD_NS - 1) / `EEP_CLK_PERIOD_NS)
`define EEP_TWC_MS 5
`define EEP_TWC_CYC ((`EEP_TWC_MS * 1000000) / `EEP_CLK_PERIOD_NS)
`define EEP_QUARTER_CYC 10
`define EEP_CTRL_CODE 4'hA
`define EEP_MEM_WORDS 1024
`define EEP_PAGE_BYTES 16
`define EEP_BIT_LAST 4'h7
`define EEP_BIT_ACK 4'h8

`endif

// ===== shared/eep_pkg.sv
package eep_pkg;
	typedef enum logic [2:0] {
		DEV_IDLE,
		DEV_CTRL,
		DEV_ADDR,
		DEV_WR,
		DEV_RD
	} eep_dev_st_t;

	typedef enum logic [1:0] {
		MST_IDLE,
		MST_START,
		MST_BYTE,
		MST_STOP
	} eep_mst_st_t;
endpackage

// ===== shared/eep_link_if.sv
interface eep_link_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic sda;

	// open-drain wire with pull-up: low when any enabled driver drives low
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

	modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
	modport mst (output scl, output sda_m_o, output sda_m_oe, input sda);
endinterface

// ===== hw/eep_dev.sv
// Notes on behaviour
// - sda changes only while scl is low
// - sda edge with scl high is framing
// - master alone drives scl and framing
// - direction follows the master's choice
// - master starts only on an idle bus
// - scl times every bit in and out
// - sda is open drain, pull-low only
// - hold sda 300 ns after scl falls
// - protect low allows reads and writes
// - protect high blocks all array writes
// - address straps are ignored entirely
// - internal write cycle ends within 5 ms
// - start is sda fall, scl high
// - stop is sda rise, scl high
// - receiver pulls sda low on ninth clock; eep_mst never does this for the byte it reads
// - no acknowledge during a programming cycle
`include "eep_params.svh"

module eep_dev #(
	parameter int WRITE_CYCLES = `EEP_TWC_CYC
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	eep_link_if.dev link,
	input wire logic wp,
	input wire logic unused_strap_zero,
	input wire logic unused_strap_one,
	input wire logic unused_strap_two,
	output logic busy
);

	function automatic logic ctrl_match(input logic [7:0] b);
		ctrl_match = (b[7:4] == `EEP_CTRL_CODE);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic scl_meta_q, scl_sync_q, scl_prev_q;
	logic sda_meta_q, sda_sync_q, sda_prev_q;
	logic wp_meta_q, wp_sync_q;
	logic scl_rise, scl_fall, start_ev, stop_ev;
	logic [1:0] hold_q;
	logic act;

	eep_pkg::eep_dev_st_t st_q;
	logic [3:0] bitcnt_q;
	logic [7:0] shift_q;
	logic [7:0] txd_q;
	logic [9:0] ptr_q;
	logic [1:0] blk_q;
	logic rw_q;
	logic mack_q;
	logic pull_q;
	logic lvl_q;

	logic [7:0] mem_q [0:`EEP_MEM_WORDS-1];
	logic [7:0] page_q [0:`EEP_PAGE_BYTES-1];
	logic [15:0] page_vld_q;
	logic wr_byte;
	logic pend_q;
	logic busy_q;
	logic [31:0] wcnt_q;

	// straps carry no meaning; they are not read anywhere

	////////////////////////////////////////////////////////////////////////
	// pins are sampled, never used as clocks
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			scl_meta_q <= 1'b1;
			scl_sync_q <= 1'b1;
			scl_prev_q <= 1'b1;
			sda_meta_q <= 1'b1;
			sda_sync_q <= 1'b1;
			sda_prev_q <= 1'b1;
			wp_meta_q <= 1'b1;
			wp_sync_q <= 1'b1;
		end else begin
			scl_meta_q <= link.scl;
			scl_sync_q <= scl_meta_q;
			scl_prev_q <= scl_sync_q;
			sda_meta_q <= link.sda;
			sda_sync_q <= sda_meta_q;
			sda_prev_q <= sda_sync_q;
			wp_meta_q <= wp;
			wp_sync_q <= wp_meta_q;
		end
	end

	assign scl_rise = scl_sync_q && !scl_prev_q;
	assign scl_fall = !scl_sync_q && scl_prev_q;
	// any sda edge during scl high is framing, never data
	assign start_ev = scl_sync_q && scl_prev_q &&
		sda_prev_q && !sda_sync_q;
	assign stop_ev = scl_sync_q && scl_prev_q &&
		!sda_prev_q && sda_sync_q;

	////////////////////////////////////////////////////////////////////////
	// output changes wait out the hold delay after scl falls; the master
	// low phase must outlast sync plus hold or bits would slip
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			hold_q <= 2'h0;
		end else if (scl_fall) begin
			hold_q <= 2'(`EEP_HOLD_CYC);
		end else if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end

	assign act = (hold_q == 2'h1) && !scl_sync_q;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= eep_pkg::DEV_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			txd_q <= 8'h00;
			ptr_q <= 10'h000;
			blk_q <= 2'h0;
			rw_q <= 1'b0;
			mack_q <= 1'b0;
			pull_q <= 1'b0;
		end else if (start_ev) begin
			st_q <= eep_pkg::DEV_CTRL;
			bitcnt_q <= 4'hF; // the fall closing a start is no bit
			pull_q <= 1'b0;
		end else if (stop_ev) begin
			st_q <= eep_pkg::DEV_IDLE;
			pull_q <= 1'b0;
		end else if (st_q != eep_pkg::DEV_IDLE) begin
			if (scl_rise) begin
				if (bitcnt_q == `EEP_BIT_ACK) begin
					mack_q <= !sda_sync_q;
				end else if (st_q != eep_pkg::DEV_RD) begin
					shift_q <= {shift_q[6:0], sda_sync_q};
				end
			end
			if (act) begin
				if (bitcnt_q == `EEP_BIT_LAST) begin
					bitcnt_q <= `EEP_BIT_ACK;
					case (st_q)
						eep_pkg::DEV_CTRL: begin
							// busy withholds the acknowledge
							pull_q <= ctrl_match(shift_q) && !busy_q;
							blk_q <= shift_q[2:1];
							rw_q <= shift_q[0];
						end
						eep_pkg::DEV_ADDR: begin
							pull_q <= !busy_q;
							ptr_q <= {blk_q, shift_q};
						end
						eep_pkg::DEV_WR: begin
							pull_q <= !busy_q;
							ptr_q[3:0] <= ptr_q[3:0] + 4'h1;
						end
						default: begin
							pull_q <= 1'b0;
						end
					endcase
				end else if (bitcnt_q == `EEP_BIT_ACK) begin
					bitcnt_q <= 4'h0;
					pull_q <= 1'b0;
					case (st_q)
						eep_pkg::DEV_CTRL: begin
							if (!ctrl_match(shift_q) || busy_q) begin
								st_q <= eep_pkg::DEV_IDLE;
							end else if (rw_q) begin
								st_q <= eep_pkg::DEV_RD;
								txd_q <= mem_q[ptr_q];
								pull_q <= !mem_q[ptr_q][7];
								ptr_q <= ptr_q + 10'h001;
							end else begin
								st_q <= eep_pkg::DEV_ADDR;
							end
						end
						eep_pkg::DEV_ADDR: begin
							st_q <= eep_pkg::DEV_WR;
						end
						eep_pkg::DEV_RD: begin
							if (mack_q) begin
								txd_q <= mem_q[ptr_q];
								pull_q <= !mem_q[ptr_q][7];
								ptr_q <= ptr_q + 10'h001;
							end else begin
								st_q <= eep_pkg::DEV_IDLE;
							end
						end
						default: begin
						end
					endcase
				end else begin
					bitcnt_q <= bitcnt_q + 4'h1;
					if (st_q == eep_pkg::DEV_RD) begin
						txd_q <= {txd_q[6:0], 1'b0};
						pull_q <= !txd_q[6];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// page buffer collects bytes; a later address byte starts a new page
	assign wr_byte = act && !start_ev && !stop_ev && !busy_q &&
		(bitcnt_q == `EEP_BIT_LAST) && (st_q == eep_pkg::DEV_WR);

	always_ff @(posedge clk_sys) begin
		if (wr_byte) begin
			page_q[ptr_q[3:0]] <= shift_q;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			page_vld_q <= 16'h0000;
		end else if (wr_byte) begin
			page_vld_q[ptr_q[3:0]] <= 1'b1;
		end else if (act && !start_ev && !stop_ev &&
			(bitcnt_q == `EEP_BIT_LAST) && (st_q == eep_pkg::DEV_ADDR)) begin
			page_vld_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stop after data launches the self-timed cycle unless protected
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pend_q <= 1'b0;
			busy_q <= 1'b0;
			wcnt_q <= 32'h0000_0000;
		end else begin
			if (wr_byte) begin
				pend_q <= 1'b1;
			end else if (start_ev || stop_ev) begin
				pend_q <= 1'b0;
			end
			if (busy_q) begin
				wcnt_q <= wcnt_q + 32'h0000_0001;
				if (wcnt_q == 32'(WRITE_CYCLES - 1)) begin
					busy_q <= 1'b0;
				end
			end else if (stop_ev && pend_q && !wp_sync_q) begin
				busy_q <= 1'b1;
				wcnt_q <= 32'h0000_0000;
			end
		end
	end

	// commit one buffered byte per cycle at the start of the cycle
	always_ff @(posedge clk_sys) begin
		if (busy_q && (wcnt_q < 32'(`EEP_PAGE_BYTES)) &&
			page_vld_q[wcnt_q[3:0]]) begin
			mem_q[{ptr_q[9:4], wcnt_q[3:0]}] <= page_q[wcnt_q[3:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// drive level is held low; only the enable toggles
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= 1'b0;
		end
	end

	assign link.sda_s_o = lvl_q;
	assign link.sda_s_oe = pull_q;
	assign busy = busy_q;

endmodule

// ===== hw/eep_mst.sv
`include "eep_params.svh"

module eep_mst (
	input wire logic clk_sys,
	input wire logic reset_n,
	eep_link_if.mst link,
	input wire logic cmd_valid,
	input wire logic cmd_read,
	input wire logic [9:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic rsp_nack,
	output logic [7:0] rsp_rdata
);

	function automatic logic [7:0] byte_for(input logic [2:0] step,
		input logic [9:0] addr, input logic [7:0] wdata);
		case (step)
			3'h0: byte_for = {`EEP_CTRL_CODE, 1'b0, addr[9:8], 1'b0};
			3'h1: byte_for = addr[7:0];
			3'h2: byte_for = wdata;
			3'h3: byte_for = {`EEP_CTRL_CODE, 1'b0, addr[9:8], 1'b1};
			default: byte_for = 8'hFF;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	eep_pkg::eep_mst_st_t st_q;
	logic [1:0] phase_q;
	logic [3:0] qcnt_q;
	logic [3:0] bit_q;
	logic [2:0] step_q;
	logic [7:0] sh_q;
	logic [7:0] rx_q;
	logic read_q;
	logic [9:0] addr_q;
	logic [7:0] wdata_q;
	logic nack_q;
	logic last_q;
	logic sda_meta_q;
	logic sda_sync_q;
	logic scl_q;
	logic oe_q;
	logic lvl_q;
	logic ready_q;
	logic rsp_valid_q;
	logic rsp_nack_q;
	logic [7:0] rsp_rdata_q;
	logic tick;
	logic accept;

	assign tick = (qcnt_q == 4'(`EEP_QUARTER_CYC - 1));
	assign accept = cmd_valid && ready_q && (st_q == eep_pkg::MST_IDLE);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sda_meta_q <= 1'b1;
			sda_sync_q <= 1'b1;
		end else begin
			sda_meta_q <= link.sda;
			sda_sync_q <= sda_meta_q;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			qcnt_q <= 4'h0;
		end else if (accept || tick || st_q == eep_pkg::MST_IDLE) begin
			qcnt_q <= 4'h0;
		end else begin
			qcnt_q <= qcnt_q + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// new frames leave idle or the stop inside a read, where both lines are high
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= eep_pkg::MST_IDLE;
			phase_q <= 2'h0;
			bit_q <= 4'h0;
			step_q <= 3'h0;
			sh_q <= 8'hFF;
			rx_q <= 8'h00;
			read_q <= 1'b0;
			addr_q <= 10'h000;
			wdata_q <= 8'h00;
			nack_q <= 1'b0;
			last_q <= 1'b0;
		end else if (accept) begin
			st_q <= eep_pkg::MST_START;
			phase_q <= 2'h0;
			step_q <= 3'h0;
			read_q <= cmd_read;
			addr_q <= cmd_addr;
			wdata_q <= cmd_wdata;
			nack_q <= 1'b0;
			last_q <= 1'b0;
		end else if (tick && st_q != eep_pkg::MST_IDLE) begin
			phase_q <= phase_q + 2'h1;
			case (st_q)
				eep_pkg::MST_START: begin
					if (phase_q == 2'h3) begin
						st_q <= eep_pkg::MST_BYTE;
						bit_q <= 4'h0;
						sh_q <= byte_for(step_q, addr_q, wdata_q);
					end
				end
				eep_pkg::MST_BYTE: begin
					if (phase_q == 2'h2) begin
						if (bit_q != `EEP_BIT_ACK) begin
							rx_q <= {rx_q[6:0], sda_sync_q};
						end else if (step_q != 3'h4 && sda_sync_q) begin
							nack_q <= 1'b1;
						end
					end
					if (phase_q == 2'h3) begin
						if (bit_q != `EEP_BIT_ACK) begin
							bit_q <= bit_q + 4'h1;
							sh_q <= {sh_q[6:0], 1'b1};
						end else begin
							bit_q <= 4'h0;
							if (nack_q || step_q == 3'h4 ||
								(step_q == 3'h2)) begin
								st_q <= eep_pkg::MST_STOP;
								last_q <= 1'b1;
							end else if (step_q == 3'h1 && read_q) begin
								st_q <= eep_pkg::MST_STOP;
								step_q <= 3'h3;
							end else begin
								step_q <= (step_q == 3'h1) ? 3'h2 : step_q + 3'h1;
								sh_q <= byte_for(step_q + 3'h1, addr_q, wdata_q);
							end
						end
					end
				end
				eep_pkg::MST_STOP: begin
					if (phase_q == 2'h3) begin
						st_q <= last_q ? eep_pkg::MST_IDLE : eep_pkg::MST_START;
					end
				end
				default: begin
					st_q <= eep_pkg::MST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// line levels follow state one cycle later; data moves only in phase 0
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= 1'b0;
			case (st_q)
				eep_pkg::MST_START: begin
					scl_q <= (phase_q == 2'h1) || (phase_q == 2'h2);
					oe_q <= phase_q[1];
				end
				eep_pkg::MST_BYTE: begin
					scl_q <= (phase_q == 2'h1) || (phase_q == 2'h2);
					oe_q <= (bit_q != `EEP_BIT_ACK) && !sh_q[7];
				end
				eep_pkg::MST_STOP: begin
					scl_q <= (phase_q != 2'h0);
					oe_q <= !phase_q[1];
				end
				default: begin
					scl_q <= 1'b1;
					oe_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ready_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_nack_q <= 1'b0;
			rsp_rdata_q <= 8'h00;
		end else begin
			ready_q <= (st_q == eep_pkg::MST_IDLE) && !accept;
			rsp_valid_q <= tick && (st_q == eep_pkg::MST_STOP) &&
				(phase_q == 2'h3) && last_q;
			if (tick && (st_q == eep_pkg::MST_STOP) && (phase_q == 2'h3) &&
				last_q) begin
				rsp_nack_q <= nack_q;
				rsp_rdata_q <= rx_q;
			end
		end
	end

	assign link.scl = scl_q;
	assign link.sda_m_o = lvl_q;
	assign link.sda_m_oe = oe_q;
	assign cmd_ready = ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_nack = rsp_nack_q;
	assign rsp_rdata = rsp_rdata_q;

endmodule

// ===== dv/eep_link_props.sv
module eep_link_props #(
	parameter int WRITE_CYCLES = 50000
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic scl,
	input wire logic sda_m_o,
	input wire logic sda_m_oe,
	input wire logic sda_s_o,
	input wire logic sda_s_oe,
	input wire logic sda,
	input wire logic busy
);
	logic [31:0] busy_cnt_q;

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////////////
	// counts cycles of the running write, too long a run must be seen
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busy_cnt_q <= 32'h0;
		end else if (busy) begin
			busy_cnt_q <= busy_cnt_q + 32'h1;
		end else begin
			busy_cnt_q <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	sequence s_low_phase;
		!scl [*7];
	endsequence

	AST_DEV_OPEN_DRAIN: assert property (!sda_s_o)
		else $error("device drives sda high");
	AST_MST_OPEN_DRAIN: assert property (!sda_m_o)
		else $error("master drives sda high");
	AST_DEV_STABLE_HIGH: assert property (
		scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("device sda moved while scl high");
	AST_DEV_HOLD: assert property (
		$changed(sda_s_oe) |-> !scl && !$past(scl, 3))
		else $error("device sda moved too soon after scl fall");
	AST_NO_ACK_BUSY: assert property (busy |-> !sda_s_oe)
		else $error("device drives sda during write cycle");
	AST_WRITE_BOUND: assert property (
		busy |-> busy_cnt_q < WRITE_CYCLES)
		else $error("write cycle too long");
	AST_ONE_DIRECTION: assert property (
		sda_s_oe && scl |-> !sda_m_oe)
		else $error("both ends drive sda in high phase");
	AST_SCL_LOW: assert property ($fell(scl) |-> s_low_phase)
		else $error("scl low phase too short");
	AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*3])
		else $error("scl high phase too short");
	AST_START_HOLD: assert property (s_start |-> ##[1:12] !scl)
		else $error("no clock after start");
	AST_STOP_IDLE: assert property (s_stop |-> scl [*8])
		else $error("bus not left idle after stop");
endmodule

// ===== dv/eeprom_two_wire_slave_port_tb.sv
module eeprom_two_wire_slave_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// short write cycle, still long enough to refuse the next control byte
	localparam int WCYC = 600;
	localparam int LIMIT = 95000;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic wp = 1'b0;
	logic [2:0] strap = 3'h0;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [9:0] cmd_addr = 10'h000;
	logic [7:0] cmd_wdata = 8'h00;
	logic busy, cmd_ready, rsp_valid, rsp_nack, nack_seen;
	logic [7:0] rsp_rdata, rdata_seen, sh, first_byte;
	logic scl_p = 1'b1;
	logic sda_p = 1'b1;
	logic [7:0] mem [0:1023];
	logic [9:0] used [$];
	logic [9:0] a;
	int bitn = 0;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;

	eep_link_if u_link();
	eep_mst u_eep_mst (.clk_sys(clk_sys), .reset_n(reset_n), .link(u_link),
		.cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
	eep_dev #(.WRITE_CYCLES(WCYC)) u_eep_dev (.clk_sys(clk_sys),
		.reset_n(reset_n), .link(u_link), .wp(wp),
		.unused_strap_zero(strap[0]), .unused_strap_one(strap[1]),
		.unused_strap_two(strap[2]), .busy(busy));
	eep_link_props #(.WRITE_CYCLES(WCYC)) u_props (.clk_sys(clk_sys),
		.reset_n(reset_n), .scl(u_link.scl), .sda_m_o(u_link.sda_m_o),
		.sda_m_oe(u_link.sda_m_oe), .sda_s_o(u_link.sda_s_o),
		.sda_s_oe(u_link.sda_s_oe), .sda(u_link.sda), .busy(busy));

	always #50 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////
	// wire monitor: first byte after each start, msb first
	always @(posedge clk_sys) begin
		scl_p <= u_link.scl;
		sda_p <= u_link.sda;
		if (u_link.scl && scl_p && sda_p && !u_link.sda) begin
			bitn <= 0;
		end else if (u_link.scl && !scl_p) begin
			sh <= {sh[6:0], u_link.sda};
			if (bitn == 7) first_byte <= {sh[6:0], u_link.sda};
			bitn <= bitn + 1;
		end
	end

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			error_cnt = error_cnt + 1;
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task end_of_test();
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] exp_byte(input logic [9:0] adr);
		return mem[adr];
	endfunction

	task cmd(input logic rd, input logic [9:0] adr, input logic [7:0] d);
		int n;
		n = 0;
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_addr <= adr;
		cmd_wdata <= d;
		strap <= 3'($urandom);
		@(posedge clk_sys);
		while (cmd_ready !== 1'b1) @(posedge clk_sys);
		cmd_valid <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		// a response that never comes counts against the run
		if (n == 4000) error_cnt = error_cnt + 1;
		nack_seen = rsp_nack;
		rdata_seen = rsp_rdata;
	endtask

	task wr(input logic [9:0] adr, input logic [7:0] d, input logic exp_nack);
		cmd(1'b0, adr, d);
		check(first_byte, {4'hA, 1'b0, adr[9:8], 1'b0});
		check(nack_seen, exp_nack);
		repeat (6) if (nack_seen) cmd(1'b0, adr, d);
		check(nack_seen, 1'b0);
		check(busy, !wp);
		if (!wp) begin
			mem[adr] = d;
			used.push_back(adr);
		end
	endtask

	task rd(input logic [9:0] adr);
		cmd(1'b1, adr, 8'h00);
		repeat (6) if (nack_seen) cmd(1'b1, adr, 8'h00);
		check(first_byte, {4'hA, 1'b0, adr[9:8], 1'b1});
		check(nack_seen, 1'b0);
		check(rdata_seen, exp_byte(adr));
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hAE3FA9F9));
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		check({u_link.scl, u_link.sda}, 2'h3);
		wr(10'h000, 8'h5A, 1'b0);
		// next write lands in the running write cycle and is refused
		wr(10'h3FF, 8'hA5, 1'b1);
		rd(10'h000);
		rd(10'h3FF);
		wp <= 1'b1;
		wr(10'h3FF, 8'h3C, 1'b0);
		rd(10'h3FF);
		wp <= 1'b0;
		repeat (10) begin
			wr(10'($urandom), 8'($urandom), 1'b0);
			a = used[$urandom % used.size()];
			rd(a);
		end
		check({u_link.scl, u_link.sda}, 2'h3);
		end_of_test();
	end
endmodule
